// >>> core/wake_pkg.sv
package wake_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_MASTER_EN = 8'h02;
  localparam logic [7:0] OFS_STS_A     = 8'h05;
  localparam logic [7:0] OFS_STS_B     = 8'h06;
  localparam logic [7:0] OFS_STS_C     = 8'h07;
  localparam logic [7:0] OFS_EN_A      = 8'h09;
  localparam logic [7:0] OFS_EN_B      = 8'h0A;
  localparam logic [7:0] OFS_EN_C      = 8'h0B;

  // ---------------------------------------------------------------
  // Reset values and implemented bits
  // ---------------------------------------------------------------
  localparam logic [7:0] RESET_VALUE    = 8'h00;
  localparam logic [7:0] MASK_A         = 8'h7F;
  localparam logic [7:0] MASK_B         = 8'hFF;
  localparam logic [7:0] MASK_C         = 8'h7C;
  localparam logic [7:0] MASK_EN_C      = 8'h7D;
  localparam logic [7:0] MASTER_EN_MASK = 8'h01;
  localparam int         MASTER_EN_BIT  = 0;
  localparam int         LOW_BATTERY_FLAG_BIT    = 0;

  // ---------------------------------------------------------------
  // Low-battery capture after standby reset release
  // ---------------------------------------------------------------
  localparam logic [1:0] INIT_CAPTURE = 2'h2;
  localparam logic [1:0] INIT_DONE    = 2'h3;

  // ---------------------------------------------------------------
  // Rising edge of a synchronised group
  // ---------------------------------------------------------------
  function automatic logic [7:0] rising(input logic [7:0] cur, input logic [7:0] prev);
    rising = cur & ~prev;
  endfunction : rising

endpackage : wake_pkg

// >>> core/status_if.sv
`timescale 1ns/10ps
`default_nettype none
interface status_if;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic [7:0] value;

  modport owner (input set_bits, input clr_bits, output value);
  modport user  (output set_bits, output clr_bits, input value);
endinterface : status_if
`default_nettype wire

// >>> core/wake_status_reg.sv
`timescale 1ns/10ps
`default_nettype none
module wake_status_reg
  import wake_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hFF
) (
  input  wire logic    clk,
  input  wire logic    rst_n,
  status_if.owner      sif
);

  logic [7:0] sts_q;
  logic [7:0] sts_d;

  // ---------------------------------------------------------------
  // Write-one-to-clear with set winning
  // ---------------------------------------------------------------
  always_comb begin
    sts_d = ((sts_q & ~sif.clr_bits) | sif.set_bits) & MASK; // RL3 RL1
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sts_q <= RESET_VALUE; // RL4
    end else begin
      sts_q <= sts_d;
    end
  end

  assign sif.value = sts_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_set_wins;
    @(posedge clk) disable iff (!rst_n)
    ((sif.set_bits & MASK) != 8'h00) |=>
      ((sts_q & $past(sif.set_bits) & MASK) == ($past(sif.set_bits) & MASK));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("status set lost"); // RL1

  property p_zero_write;
    @(posedge clk) disable iff (!rst_n)
    (sif.set_bits == 8'h00 && sif.clr_bits == 8'h00) |=> $stable(sts_q);
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("status changed unasked"); // RL3

endmodule : wake_status_reg
`default_nettype wire

// >>> core/wake_event_status_bank.sv
// Notes on behaviour
// RL1 - Status bits set on any source event, ignoring individual and master enables.
// RL2 - An enabled set status bit asserts the wake output.
// RL3 - Writing one clears a status bit; writing zero leaves it alone.
// RL4 - Status registers reset to zero only on standby power-on reset.
// RL5 - Group A: watchdog, pins 21, 22, grouped status, 27, 32, 33; bit 7 reserved.
// RL6 - Group B bit n holds wake status of pin fifty plus n.
// RL7 - Group C: low battery, reserved, pins 60, 61, mouse, key, power button.
// RL8 - Low battery set at standby reset on replacement or drop below 1.2V.
// RL9 - Low battery set at main reset if battery fell below 2.4 volts.
// RL10 - Group C reads 0x01 after standby reset with battery-only low event.
// RL11 - Low battery drives wake only when enabled; it is no wake event.
// RL12 - Master enable bit 0 at offset 02 gates all sources.
// RL13 - Wake needs status bit, matching enable bit and master enable.
// RL14 - Wake output is inverted OR of enabled status, gated by master.
`timescale 1ns/10ps
`default_nettype none
module wake_event_status_bank
  import wake_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] wake_src_a,
  input  wire logic [7:0] wake_src_b,
  input  wire logic [7:0] wake_src_c,
  input  wire logic       battery_lost_vbat,
  input  wire logic       main_por_event,
  input  wire logic       battery_below_2v4,
  output logic            wake_out_n
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [26:0] meta_q;
  logic [26:0] sync_q;
  logic [26:0] prev_q;
  logic [26:0] pins;

  assign pins = {battery_below_2v4, main_por_event, battery_lost_vbat,
                 wake_src_c, wake_src_b, wake_src_a};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  logic [7:0] rise_a;
  logic [7:0] rise_b;
  logic [7:0] rise_c;
  logic       main_por_rise;

  always_comb begin
    rise_a        = rising(sync_q[7:0], prev_q[7:0]) & MASK_A;     // RL1 RL5
    rise_b        = rising(sync_q[15:8], prev_q[15:8]) & MASK_B;   // RL1 RL6
    rise_c        = rising(sync_q[23:16], prev_q[23:16]) & MASK_C; // RL1 RL7 RL11
    main_por_rise = sync_q[25] & ~prev_q[25];
  end

  // ---------------------------------------------------------------
  // Low-battery capture
  // ---------------------------------------------------------------
  logic [1:0] init_q;
  logic [1:0] init_d;
  logic       low_battery_flag_set;

  always_comb begin
    init_d      = init_q;
    if (init_q != INIT_DONE) begin
      init_d = init_q + 2'h1;
    end
    low_battery_flag_set = ((init_q == INIT_CAPTURE) && sync_q[24]) // RL8 RL10
                | (main_por_rise && sync_q[26]);            // RL9
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_q <= 2'h0;
    end else begin
      init_q <= init_d;
    end
  end

  // ---------------------------------------------------------------
  // Status registers
  // ---------------------------------------------------------------
  status_if if_a ();
  status_if if_b ();
  status_if if_c ();

  logic wr_sts_a;
  logic wr_sts_b;
  logic wr_sts_c;

  always_comb begin
    wr_sts_a        = reg_wr && (reg_addr == OFS_STS_A);
    wr_sts_b        = reg_wr && (reg_addr == OFS_STS_B);
    wr_sts_c        = reg_wr && (reg_addr == OFS_STS_C);
    if_a.set_bits   = rise_a;
    if_b.set_bits   = rise_b;
    if_c.set_bits   = rise_c | {7'h00, low_battery_flag_set};
    if_a.clr_bits   = wr_sts_a ? reg_wdata : 8'h00; // RL3
    if_b.clr_bits   = wr_sts_b ? reg_wdata : 8'h00; // RL3
    if_c.clr_bits   = wr_sts_c ? reg_wdata : 8'h00; // RL3
  end

  wake_status_reg #(.MASK(MASK_A)) u_sts_a (.clk(clk), .rst_n(rst_n), .sif(if_a.owner));
  wake_status_reg #(.MASK(MASK_B)) u_sts_b (.clk(clk), .rst_n(rst_n), .sif(if_b.owner));
  wake_status_reg #(.MASK(MASK_C | 8'h01)) u_sts_c (.clk(clk), .rst_n(rst_n), .sif(if_c.owner));

  // ---------------------------------------------------------------
  // Enable registers
  // ---------------------------------------------------------------
  logic [7:0] master_q;
  logic [7:0] master_d;
  logic [7:0] en_a_q;
  logic [7:0] en_a_d;
  logic [7:0] en_b_q;
  logic [7:0] en_b_d;
  logic [7:0] en_c_q;
  logic [7:0] en_c_d;

  always_comb begin
    master_d = master_q;
    en_a_d   = en_a_q;
    en_b_d   = en_b_q;
    en_c_d   = en_c_q;
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_MASTER_EN: master_d = reg_wdata & MASTER_EN_MASK; // RL12
        OFS_EN_A:      en_a_d   = reg_wdata & MASK_A;
        OFS_EN_B:      en_b_d   = reg_wdata & MASK_B;
        OFS_EN_C:      en_c_d   = reg_wdata & MASK_EN_C;      // RL11
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      master_q <= RESET_VALUE;
      en_a_q   <= RESET_VALUE;
      en_b_q   <= RESET_VALUE;
      en_c_q   <= RESET_VALUE;
    end else begin
      master_q <= master_d;
      en_a_q   <= en_a_d;
      en_b_q   <= en_b_d;
      en_c_q   <= en_c_d;
    end
  end

  // ---------------------------------------------------------------
  // Wake output and read data
  // ---------------------------------------------------------------
  logic       pending;
  logic       wake_n_d;
  logic [7:0] rdata_d;

  always_comb begin
    pending  = |((if_a.value & en_a_q) | (if_b.value & en_b_q)
               | (if_c.value & en_c_q));                  // RL2 RL13 RL11
    wake_n_d = ~(master_q[MASTER_EN_BIT] & pending);      // RL12 RL14
    unique case (reg_addr)
      OFS_MASTER_EN: rdata_d = master_q;
      OFS_STS_A:     rdata_d = if_a.value;
      OFS_STS_B:     rdata_d = if_b.value;
      OFS_STS_C:     rdata_d = if_c.value;
      OFS_EN_A:      rdata_d = en_a_q;
      OFS_EN_B:      rdata_d = en_b_q;
      OFS_EN_C:      rdata_d = en_c_q;
      default:       rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_out_n <= 1'b1;
      reg_rdata  <= RESET_VALUE;
    end else begin
      wake_out_n <= wake_n_d;
      reg_rdata  <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_wake_on;
    @(posedge clk) disable iff (!rst_n)
    (master_q[MASTER_EN_BIT] && pending) |=> !wake_out_n;
  endproperty
  a_wake_on: assert property (p_wake_on) else $error("enabled status gave no wake"); // RL2

  property p_master_off;
    @(posedge clk) disable iff (!rst_n)
    !master_q[MASTER_EN_BIT] |=> wake_out_n;
  endproperty
  a_master_off: assert property (p_master_off) else $error("wake without master"); // RL12

  property p_wake_cause;
    @(posedge clk) disable iff (!rst_n)
    !wake_out_n |-> $past(pending) && $past(master_q[MASTER_EN_BIT]);
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake without cause"); // RL14

  property p_low_battery_flag_gate;
    @(posedge clk) disable iff (!rst_n)
    (master_q[MASTER_EN_BIT] && if_c.value[LOW_BATTERY_FLAG_BIT] && !en_c_q[LOW_BATTERY_FLAG_BIT]
     && ((if_a.value & en_a_q) == 8'h00) && ((if_b.value & en_b_q) == 8'h00)
     && ((if_c.value & en_c_q) == 8'h00)) |=> wake_out_n;
  endproperty
  a_low_battery_flag_gate: assert property (p_low_battery_flag_gate) else $error("low battery woke"); // RL11

  property p_group_a_set;
    @(posedge clk) disable iff (!rst_n)
    (rise_a != 8'h00) ##1 (if_a.clr_bits == 8'h00) |->
      ((if_a.value & $past(rise_a)) == $past(rise_a))
      ##1 ((if_a.value & $past(rise_a, 2)) == $past(rise_a, 2));
  endproperty
  a_group_a_set: assert property (p_group_a_set) else $error("group A event lost"); // RL1

  property p_reserved;
    @(posedge clk) disable iff (!rst_n)
    !if_a.value[7] && !if_c.value[1] && !if_c.value[7];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set"); // RL5

  property p_low_battery_flag_vtr;
    @(posedge clk) disable iff (!rst_n)
    (init_q == INIT_CAPTURE && sync_q[24]) |=> if_c.value[LOW_BATTERY_FLAG_BIT];
  endproperty
  a_low_battery_flag_vtr: assert property (p_low_battery_flag_vtr) else $error("low battery missed"); // RL8

  property p_low_battery_flag_main;
    @(posedge clk) disable iff (!rst_n)
    (main_por_rise && sync_q[26]) |=> if_c.value[LOW_BATTERY_FLAG_BIT];
  endproperty
  a_low_battery_flag_main: assert property (p_low_battery_flag_main) else $error("main reset flag missed"); // RL9

  property p_group_b_set;
    @(posedge clk) disable iff (!rst_n)
    (rise_b != 8'h00) |=> ((if_b.value & $past(rise_b)) == $past(rise_b));
  endproperty
  a_group_b_set: assert property (p_group_b_set) else $error("group B event lost"); // RL6

endmodule : wake_event_status_bank
`default_nettype wire

// >>> sim/host_wake_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module host_wake_monitor (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       wake_out_n,
  output logic      [7:0] wake_count
);
  // ---------------------------------------------------------------
  // Count wake requests seen by the host
  // ---------------------------------------------------------------
  logic       prev_q;
  logic       prev_d;
  logic [7:0] count_q;
  logic [7:0] count_d;

  always_comb begin
    prev_d  = wake_out_n;
    count_d = count_q;
    if (prev_q && !wake_out_n) begin
      count_d = count_q + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q  <= 1'b1;
      count_q <= 8'h00;
    end else begin
      prev_q  <= prev_d;
      count_q <= count_d;
    end
  end

  assign wake_count = count_q;
endmodule : host_wake_monitor
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
  import wake_pkg::*;
;
  logic       clk;
  logic       rst_n;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] wake_src_a;
  logic [7:0] wake_src_b;
  logic [7:0] wake_src_c;
  logic       battery_lost_vbat;
  logic       main_por_event;
  logic       battery_below_2v4;
  logic       wake_out_n;
  logic [7:0] wake_count;
  int         fails;
  int         num_checks;

  wake_event_status_bank DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .wake_src_a(wake_src_a), .wake_src_b(wake_src_b), .wake_src_c(wake_src_c),
    .battery_lost_vbat(battery_lost_vbat), .main_por_event(main_por_event),
    .battery_below_2v4(battery_below_2v4), .wake_out_n(wake_out_n));
  host_wake_monitor host (.clk(clk), .rst_n(rst_n), .wake_out_n(wake_out_n),
    .wake_count(wake_count));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string w, input logic [7:0] seen, input logic [7:0] e);
    num_checks++;
    if (seen !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", w, e, seen);
    end
  endtask : check

  task automatic check_wake(input logic e);
    repeat (2) @(negedge clk);
    check("wake_out_n", {7'h00, wake_out_n}, {7'h00, e});
  endtask : check_wake

  task automatic do_reset(input logic lost);
    rst_n = 1'b0;
    battery_lost_vbat = lost;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic chk_rd(input string w, input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    @(negedge clk);
    check(w, reg_rdata, e);
  endtask : chk_rd

  task automatic pulse(input int g, input logic [7:0] b);
    if (g == 0) wake_src_a = b;
    else if (g == 1) wake_src_b = b;
    else wake_src_c = b;
    repeat (3) @(negedge clk);
    wake_src_a = 8'h00;
    wake_src_b = 8'h00;
    wake_src_c = 8'h00;
    repeat (5) @(negedge clk);
  endtask : pulse

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_events;
    chk_rd("sts_a", 8'h05, 8'h00);
    chk_rd("sts_c", 8'h07, 8'h00);
    wr(8'h20, 8'hFF);
    chk_rd("unmapped", 8'h20, 8'h00);
    pulse(0, 8'hFF);
    pulse(1, 8'hFF);
    pulse(2, 8'hFF);
    chk_rd("sts_a", 8'h05, 8'h7F);
    chk_rd("sts_b", 8'h06, 8'hFF);
    chk_rd("sts_c", 8'h07, 8'h7C);
    check_wake(1'b1);
    wr(8'h05, 8'h00);
    chk_rd("sts_a", 8'h05, 8'h7F);
    wr(8'h05, 8'h01);
    chk_rd("sts_a", 8'h05, 8'h7E);
    for (int g = 0; g < 3; g++) wr(8'h05 + 8'(g), 8'hFF);
    $display("test events done");
  endtask : t_events

  task automatic t_map;
    logic [7:0] m [3];
    m = '{8'h7F, 8'hFF, 8'h7C};
    for (int g = 0; g < 3; g++) begin
      for (int n = 0; n < 8; n++) begin
        pulse(g, 8'h01 << n);
        chk_rd("bit map", 8'h05 + 8'(g), (8'h01 << n) & m[g]);
        wr(8'h05 + 8'(g), 8'hFF);
      end
    end
    $display("test map done");
  endtask : t_map

  task automatic t_gating;
    pulse(0, 8'h01);
    wr(8'h09, 8'h01);
    check_wake(1'b1);
    wr(8'h02, 8'hFF);
    chk_rd("master", 8'h02, 8'h01);
    check_wake(1'b0);
    check("wake count", wake_count, 8'h01);
    wr(8'h02, 8'h00);
    check_wake(1'b1);
    wr(8'h02, 8'h01);
    wr(8'h09, 8'h00);
    check_wake(1'b1);
    wr(8'h09, 8'h01);
    check_wake(1'b0);
    wr(8'h05, 8'h01);
    check_wake(1'b1);
    wr(8'h0A, 8'h80);
    pulse(1, 8'h80);
    check_wake(1'b0);
    wr(8'h06, 8'h80);
    check_wake(1'b1);
    $display("test gating done");
  endtask : t_gating

  task automatic t_lowbat;
    do_reset(1'b1);
    chk_rd("sts_c", 8'h07, 8'h01);
    check_wake(1'b1);
    wr(8'h02, 8'h01);
    wr(8'h0B, 8'h01);
    check_wake(1'b0);
    wr(8'h07, 8'h01);
    check_wake(1'b1);
    pulse(0, 8'h40);
    for (int k = 1; k >= 0; k--) begin
      battery_below_2v4 = k[0];
      main_por_event = 1'b1;
      repeat (4) @(negedge clk);
      main_por_event = 1'b0;
      repeat (4) @(negedge clk);
      chk_rd("sts_c", 8'h07, {7'h00, k[0]});
      chk_rd("sts_a", 8'h05, 8'h40);
      wr(8'h07, 8'h01);
    end
    do_reset(1'b0);
    chk_rd("sts_a", 8'h05, 8'h00);
    chk_rd("sts_c", 8'h07, 8'h00);
    $display("test low battery done");
  endtask : t_lowbat

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  // ---------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #100000;
    fails++;
    report_and_stop();
  end

  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    wake_src_a = 8'h00;
    wake_src_b = 8'h00;
    wake_src_c = 8'h00;
    battery_lost_vbat = 1'b0;
    main_por_event = 1'b0;
    battery_below_2v4 = 1'b0;
    @(negedge clk);
    do_reset(1'b0);
    t_events();
    t_map();
    t_gating();
    t_lowbat();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
